// [clock_monitor.sv]
// Oscillator edge sampler, clock monitor and clock quality check.
// Assumes the oscillator pin is asynchronous and slower than half of core_clk.
`timescale 1ns/1ps
`default_nettype none
module clock_monitor #(
  parameter int unsigned WINDOW_CYC = startup_seq_pkg::MON_WINDOW_CYC,
  parameter int unsigned FAIL_EDGES = startup_seq_pkg::MON_FAIL_EDGES,
  parameter int unsigned GOOD_WINDOWS = startup_seq_pkg::QC_GOOD_WINDOWS
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic osc_pin,
  osc_mon_if.mon mon
);

  localparam int WW = $clog2(WINDOW_CYC + 1);
  localparam int EW = $clog2(FAIL_EDGES + 1);
  localparam int GW = $clog2(GOOD_WINDOWS + 1);

  // Refuse settings the counters cannot serve
  if (WINDOW_CYC < 2 || FAIL_EDGES < 1 || GOOD_WINDOWS < 1)
  begin : bad_params
    $error("clock_monitor: window, edge and good-window counts must be positive");
  end

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic [WW-1:0] win_reg;
  logic [EW-1:0] edges_reg;
  logic [GW-1:0] good_reg;
  logic window_end;
  logic window_good;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser, then edge detection on the second stage
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= osc_pin;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign mon.osc_edge = sync2_reg & ~prev_reg;
  assign window_end = (win_reg == WW'(WINDOW_CYC - 1));
  assign window_good = (edges_reg == EW'(FAIL_EDGES));

  // Measurement window and saturating edge count
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || mon.restart || window_end)
    begin
      win_reg <= '0;
      edges_reg <= '0;
    end
    else
    begin
      win_reg <= win_reg + WW'(1);
      if (mon.osc_edge && !window_good)
        edges_reg <= edges_reg + EW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RL11 frequency below threshold
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      mon.mon_fail <= 1'b0;
    else if (window_end)
      mon.mon_fail <= ~window_good;
  end

  // RL5 quality needs consecutive good windows
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || mon.restart)
      good_reg <= '0;
    else if (window_end && !window_good)
      good_reg <= '0;
    else if (window_end && good_reg != GW'(GOOD_WINDOWS))
      good_reg <= good_reg + GW'(1);
  end

  assign mon.qc_ok = (good_reg == GW'(GOOD_WINDOWS));

endmodule : clock_monitor
`default_nettype wire

// [ext_clock_source.sv]
// Model of the crystal or external clock on the oscillator pin.
// Assumes the bench gates it by run and the sequencer gates it by osc_enable.
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source #(
  parameter int HALF_NS = 250
) (
  input wire logic run,
  input wire logic osc_enable,
  output logic osc_pin
);
  // Square wave while enabled, stands low while stopped
  initial
  begin
    osc_pin = 1'b0;
    forever
    begin
      #(HALF_NS);
      if (run && osc_enable)
        osc_pin = ~osc_pin;
      else
        osc_pin = 1'b0;
    end
  end
endmodule : ext_clock_source
`default_nettype wire

// [osc_mon_if.sv]
// Interface between the sequencer and its clock monitor.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
`default_nettype none
interface osc_mon_if;
  logic restart;
  logic osc_edge;
  logic qc_ok;
  logic mon_fail;

  modport mon (input restart, output osc_edge, output qc_ok, output mon_fail);
  modport ctl (output restart, input osc_edge, input qc_ok, input mon_fail);
endinterface : osc_mon_if
`default_nettype wire

// [startup_clock_quality_sequencer.sv]
// Startup and recovery sequencer of the clock and reset generator.
// Assumes raw oscillator, reset, strap and external interrupt pins; low-power
// requests, internal interrupts, low-voltage reset and flag clear come from
// core_clk logic.
//
// Functional notes
// RL1: After power-on reset, check oscillator or self clock
// RL2: Quality check time-out from 0.45 to 2.5 s (code rejects only zero and values above 2.5 s)
// RL3: Reset pin held two oscillator periods gives reset
// RL4: Pin reset with running oscillator skips quality check
// RL5: Quality check on power-on, stop, oscillator failure
// RL6: Stop wakes on external interrupt after quality check
// RL7: Wait and pseudo stop wake on any interrupt
// RL8: Wait wake fetches vector within 14 bus cycles
// RL9: Pseudo stop lowers regulator, adds its recovery time
// RL10: Strap sampled during reset: low Pierce, high Colpitts
// RL11: Monitor fails below assert frequency threshold
// RL12: Power-on flag set by power-on reset
// RL13: Processor held, clocks gated until source valid
`timescale 1ns/1ps
`default_nettype none
module startup_clock_quality_sequencer #(
  parameter int unsigned CQ_TIMEOUT_CYC = startup_seq_pkg::CQ_TIMEOUT_CYC,
  parameter int unsigned WAIT_RECOVERY_CYC = startup_seq_pkg::WAIT_RECOVERY_CYC,
  parameter int unsigned REG_RECOVERY_CYC = startup_seq_pkg::REG_RECOVERY_CYC,
  parameter int unsigned RESET_STARTUP_OSC = startup_seq_pkg::RESET_STARTUP_OSC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic lvr_reset,
  input wire logic osc_pin,
  input wire logic ext_reset_pin_n,
  input wire logic osc_type_select_strap,
  input wire logic ext_irq_pin,
  input wire logic int_irq,
  input wire logic stop_req,
  input wire logic pseudo_stop_req,
  input wire logic wait_req,
  input wire logic por_flag_clear,
  output logic cpu_reset,
  output logic sys_clk_enable,
  output logic self_clock_mode,
  output logic osc_enable,
  output logic regulator_reduced,
  output logic fetch_int_vector,
  output logic clock_monitor_fail,
  output logic power_on_reset_flag,
  output logic osc_colpitts_sel
);

  localparam int TW = $clog2(CQ_TIMEOUT_CYC + 1);
  localparam int DW = $clog2(REG_RECOVERY_CYC + WAIT_RECOVERY_CYC + 1);
  localparam int OW = $clog2(RESET_STARTUP_OSC + 1);

  // RL2 time-out limited to 1 cycle up to the window's upper end
  if (CQ_TIMEOUT_CYC < 1 || CQ_TIMEOUT_CYC > startup_seq_pkg::CQ_TIMEOUT_MAX_CYC)
  begin : bad_timeout
    $error("sequencer: quality check time-out out of range");
  end
  if (WAIT_RECOVERY_CYC < 1 || WAIT_RECOVERY_CYC > 14 || RESET_STARTUP_OSC < 1)
  begin : bad_counts
    $error("sequencer: recovery or startup count out of range");
  end

  osc_mon_if mon_bus ();

  startup_seq_pkg::seq_state_t state_reg;
  startup_seq_pkg::seq_state_t state_next;
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic strap_s1_reg;
  logic strap_s2_reg;
  logic irq_s1_reg;
  logic irq_s2_reg;
  logic [1:0] low_osc_reg;
  logic ext_rst_seen;
  logic osc_running_reg;
  logic [TW-1:0] timeout_reg;
  logic [DW-1:0] delay_reg;
  logic [DW-1:0] delay_load;
  logic [OW-1:0] osc_cnt_reg;
  logic timed_out;
  logic in_qc;
  logic qc_restart;

  clock_monitor u_monitor (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .osc_pin(osc_pin),
    .mon(mon_bus.mon)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= 1'b1;
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
      irq_s1_reg <= 1'b0;
      irq_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= ext_reset_pin_n;
      rst_s2_reg <= rst_s1_reg;
      strap_s1_reg <= osc_type_select_strap;
      strap_s2_reg <= strap_s1_reg;
      irq_s1_reg <= ext_irq_pin;
      irq_s2_reg <= irq_s1_reg;
    end
  end

  // RL3 count oscillator edges while pin low
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || rst_s2_reg)
      low_osc_reg <= 2'h0;
    else if (mon_bus.osc_edge && low_osc_reg != 2'(startup_seq_pkg::MIN_RESET_PULSE_OSC))
      low_osc_reg <= low_osc_reg + 2'h1;
  end

  assign ext_rst_seen = (low_osc_reg == 2'(startup_seq_pkg::MIN_RESET_PULSE_OSC));
  assign in_qc = (state_reg == startup_seq_pkg::ST_QC) || (state_reg == startup_seq_pkg::ST_STOP_QC);
  assign timed_out = (timeout_reg == TW'(CQ_TIMEOUT_CYC - 1));
  assign mon_bus.restart = qc_restart;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    state_next = state_reg;
    qc_restart = 1'b0;
    delay_load = DW'(WAIT_RECOVERY_CYC);
    case (state_reg)
      startup_seq_pkg::ST_QC:
      begin
        // RL1 start on oscillator or self clock
        if (mon_bus.qc_ok || timed_out)
          state_next = startup_seq_pkg::ST_RUN;
      end
      startup_seq_pkg::ST_EXT_RST:
      begin
        if (rst_s2_reg)
        begin
          // RL4 skip check when oscillator ran
          if (osc_running_reg)
            state_next = startup_seq_pkg::ST_RST_STARTUP;
          else
          begin
            state_next = startup_seq_pkg::ST_QC;
            qc_restart = 1'b1;
          end
        end
      end
      startup_seq_pkg::ST_RST_STARTUP:
      begin
        if (osc_cnt_reg == OW'(RESET_STARTUP_OSC))
          state_next = startup_seq_pkg::ST_RUN;
      end
      startup_seq_pkg::ST_RUN:
      begin
        if (stop_req)
          state_next = startup_seq_pkg::ST_STOP;
        else if (pseudo_stop_req)
          state_next = startup_seq_pkg::ST_PSTOP;
        else if (wait_req)
          state_next = startup_seq_pkg::ST_WAIT;
      end
      startup_seq_pkg::ST_WAIT:
      begin
        // RL7 any interrupt wakes
        if (int_irq || irq_s2_reg)
          state_next = startup_seq_pkg::ST_WAKE;
      end
      startup_seq_pkg::ST_PSTOP:
      begin
        // RL9 regulator recovery added
        if (int_irq || irq_s2_reg)
        begin
          state_next = startup_seq_pkg::ST_WAKE;
          delay_load = DW'(REG_RECOVERY_CYC + WAIT_RECOVERY_CYC);
        end
      end
      startup_seq_pkg::ST_STOP:
      begin
        // RL6 only external interrupt wakes
        if (irq_s2_reg)
        begin
          state_next = startup_seq_pkg::ST_STOP_QC;
          qc_restart = 1'b1;
        end
      end
      startup_seq_pkg::ST_STOP_QC:
      begin
        if (mon_bus.qc_ok || timed_out)
          state_next = startup_seq_pkg::ST_WAKE;
        delay_load = DW'(1);
      end
      startup_seq_pkg::ST_WAKE:
      begin
        if (delay_reg == DW'(1))
          state_next = startup_seq_pkg::ST_RUN;
      end
      default:
        state_next = startup_seq_pkg::ST_QC;
    endcase
    // RL3 pin reset overrides every state; low-voltage reset overrides it
    if (ext_rst_seen)
      state_next = startup_seq_pkg::ST_EXT_RST;
    if (lvr_reset)
    begin
      state_next = startup_seq_pkg::ST_QC;
      qc_restart = 1'b1;
    end
  end

  // State register; power-on reset starts the quality check
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      state_reg <= startup_seq_pkg::ST_QC;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // RL2 quality check time-out counter
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !in_qc || qc_restart)
      timeout_reg <= '0;
    else if (!timed_out)
      timeout_reg <= timeout_reg + TW'(1);
  end

  // RL8 wake recovery delay
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      delay_reg <= '0;
    else if (state_reg != startup_seq_pkg::ST_WAKE)
      delay_reg <= delay_load;
    else if (delay_reg != DW'(1))
      delay_reg <= delay_reg - DW'(1);
  end

  // Oscillator periods of reset startup
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || state_reg != startup_seq_pkg::ST_RST_STARTUP)
      osc_cnt_reg <= '0;
    else if (mon_bus.osc_edge && osc_cnt_reg != OW'(RESET_STARTUP_OSC))
      osc_cnt_reg <= osc_cnt_reg + OW'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // RL5 clock source selection and oscillator failure
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      osc_running_reg <= 1'b0;
      self_clock_mode <= 1'b0;
    end
    else if (in_qc && mon_bus.qc_ok)
    begin
      osc_running_reg <= 1'b1;
      self_clock_mode <= 1'b0;
    end
    else if (in_qc && timed_out)
    begin
      osc_running_reg <= 1'b0;
      self_clock_mode <= 1'b1;
    end
    else if (state_reg == startup_seq_pkg::ST_RUN && osc_running_reg && mon_bus.mon_fail)
    begin
      osc_running_reg <= 1'b0;
      self_clock_mode <= 1'b1;
    end
    else if (state_reg == startup_seq_pkg::ST_RUN && self_clock_mode && mon_bus.qc_ok)
    begin
      osc_running_reg <= 1'b1;
      self_clock_mode <= 1'b0;
    end
    else if (state_reg == startup_seq_pkg::ST_STOP)
      osc_running_reg <= 1'b0;
  end

  // RL13 reset held, clocks gated until ready
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cpu_reset <= 1'b1;
      sys_clk_enable <= 1'b0;
    end
    else
    begin
      cpu_reset <= (state_next == startup_seq_pkg::ST_QC) || (state_next == startup_seq_pkg::ST_EXT_RST) ||
        (state_next == startup_seq_pkg::ST_RST_STARTUP);
      sys_clk_enable <= (state_next == startup_seq_pkg::ST_RUN);
    end
  end

  // Oscillator and regulator control
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      osc_enable <= 1'b1;
      regulator_reduced <= 1'b0;
    end
    else
    begin
      osc_enable <= (state_next != startup_seq_pkg::ST_STOP);
      // RL9 reduced regulator in pseudo stop
      regulator_reduced <= (state_next == startup_seq_pkg::ST_PSTOP);
    end
  end

  // RL8 vector fetch pulse on wake
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      fetch_int_vector <= 1'b0;
    else
      fetch_int_vector <= (state_reg == startup_seq_pkg::ST_WAKE) && (state_next == startup_seq_pkg::ST_RUN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // RL11 monitor failure while oscillator on
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      clock_monitor_fail <= 1'b0;
    else
      clock_monitor_fail <= mon_bus.mon_fail && osc_enable;
  end

  // RL12 power-on flag, set by power-on reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      power_on_reset_flag <= startup_seq_pkg::POR_FLAG_RESET;
    else if (por_flag_clear)
      power_on_reset_flag <= 1'b0;
  end

  // RL10 strap captured while reset held
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      osc_colpitts_sel <= startup_seq_pkg::OSC_TYPE_PIERCE;
    else if (cpu_reset)
      osc_colpitts_sel <= strap_s2_reg;
  end

endmodule : startup_clock_quality_sequencer
`default_nettype wire

// [startup_seq_assertions.sv]
// Port-level assertions for the startup and clock quality sequencer.
// Assumes one core_clk domain with sys_rst as its synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module startup_seq_assertions #(
  parameter int CQ_TIMEOUT_CYC = 20000,
  parameter int REG_RECOVERY_CYC = 100
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic lvr_reset,
  input wire logic ext_reset_pin_n,
  input wire logic ext_irq_pin,
  input wire logic int_irq,
  input wire logic stop_req,
  input wire logic pseudo_stop_req,
  input wire logic wait_req,
  input wire logic por_flag_clear,
  input wire logic cpu_reset,
  input wire logic sys_clk_enable,
  input wire logic self_clock_mode,
  input wire logic osc_enable,
  input wire logic fetch_int_vector,
  input wire logic clock_monitor_fail,
  input wire logic power_on_reset_flag,
  input wire logic osc_colpitts_sel
);
  localparam int PSTOP_MAX = REG_RECOVERY_CYC + 18;
  logic [1:0] lp_reg;
  logic [13:0] qc_cnt_reg;
  int rst_cnt_reg;

  ////////////////////////////////////////
  // Low-power mode entered from run, dropped on wake or reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || cpu_reset || fetch_int_vector)
      lp_reg <= 2'h0;
    else if (sys_clk_enable && stop_req)
      lp_reg <= 2'h3;
    else if (sys_clk_enable && pseudo_stop_req)
      lp_reg <= 2'h2;
    else if (sys_clk_enable && wait_req)
      lp_reg <= 2'h1;
  end

  // Cycles of oscillator running since a stop wake began
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || lp_reg != 2'h3 || !osc_enable)
      qc_cnt_reg <= 14'h0;
    else if (qc_cnt_reg != 14'h3fff)
      qc_cnt_reg <= qc_cnt_reg + 14'h1;
  end

  // Cycles the processor is held with no reset source active
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !cpu_reset || lvr_reset || !ext_reset_pin_n)
      rst_cnt_reg <= 0;
    else
      rst_cnt_reg <= rst_cnt_reg + 1;
  end

  ////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_fetch_pulse;
    fetch_int_vector && sys_clk_enable ##1 !fetch_int_vector;
  endsequence
  sequence s_no_ext_wake;
    (!ext_irq_pin) [*3] ##0 (lp_reg == 2'h3 && !osc_enable);
  endsequence

  a_release_together: assert property ($fell(cpu_reset) |-> sys_clk_enable)
    else $error("clocks not enabled at reset release");
  a_gated_in_reset: assert property (cpu_reset |-> !sys_clk_enable)
    else $error("clocks enabled while processor held");
  a_reset_time_bound: assert property (cpu_reset |-> rst_cnt_reg <= CQ_TIMEOUT_CYC + 200)
    else $error("startup exceeded the check time-out");
  a_wait_wake_time: assert property (lp_reg == 2'h1 && int_irq && !fetch_int_vector |-> ##[1:16] fetch_int_vector)
    else $error("wait wake too slow");
  a_pstop_wake_time: assert property (lp_reg == 2'h2 && (int_irq || ext_irq_pin) && !fetch_int_vector
    |-> ##[1:PSTOP_MAX] fetch_int_vector)
    else $error("pseudo stop wake too slow");
  a_fetch_one_pulse: assert property (fetch_int_vector |-> s_fetch_pulse)
    else $error("vector fetch not a single run cycle");
  a_stop_osc_off: assert property (sys_clk_enable && stop_req && !lvr_reset |-> ##[1:2] !osc_enable)
    else $error("oscillator not stopped in stop");
  a_stop_ext_only: assert property (s_no_ext_wake |=> !osc_enable)
    else $error("stop left without external interrupt");
  a_stop_wake_qc: assert property (fetch_int_vector && lp_reg == 2'h3 |-> qc_cnt_reg >= 14'd7000)
    else $error("stop wake skipped quality check");
  a_monitor_self_clk: assert property ($rose(clock_monitor_fail) && sys_clk_enable |-> ##[0:1] self_clock_mode)
    else $error("monitor failure kept oscillator clock");
  a_flag_clear: assert property (por_flag_clear |=> !power_on_reset_flag)
    else $error("power-on flag not cleared");
  a_flag_no_set: assert property (!power_on_reset_flag |=> !power_on_reset_flag)
    else $error("power-on flag set without power-on");
  a_strap_frozen: assert property (!cpu_reset && !$past(cpu_reset) |-> $stable(osc_colpitts_sel))
    else $error("oscillator select changed outside reset");
endmodule : startup_seq_assertions

bind startup_clock_quality_sequencer startup_seq_assertions #(
  .CQ_TIMEOUT_CYC(CQ_TIMEOUT_CYC),
  .REG_RECOVERY_CYC(REG_RECOVERY_CYC)
) u_chk (.core_clk, .sys_rst, .lvr_reset, .ext_reset_pin_n, .ext_irq_pin, .int_irq, .stop_req,
  .pseudo_stop_req, .wait_req, .por_flag_clear, .cpu_reset, .sys_clk_enable, .self_clock_mode,
  .osc_enable, .fetch_int_vector, .clock_monitor_fail, .power_on_reset_flag, .osc_colpitts_sel);
`default_nettype wire

// [startup_seq_pkg.sv]
// Shared constants and types for the startup and clock quality sequencer.
// Assumes a single core clock at 20 MHz; the millisecond and nanosecond timings are converted to cycles from it here.
package startup_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Core clock
  localparam int unsigned CORE_CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PER_US = CORE_CLK_HZ / 1_000_000;

  ////////////////////////////////////////////////////////////////////////////
  // Clock quality check time-out, documented window and chosen value
  localparam int unsigned CQ_TIMEOUT_MIN_MS = 450;
  localparam int unsigned CQ_TIMEOUT_MAX_MS = 2500;
  localparam int unsigned CQ_TIMEOUT_MS = 1000;
  localparam int unsigned CQ_TIMEOUT_CYC = (CORE_CLK_HZ / 1000) * CQ_TIMEOUT_MS;
  localparam int unsigned CQ_TIMEOUT_MIN_CYC = (CORE_CLK_HZ / 1000) * CQ_TIMEOUT_MIN_MS;
  localparam int unsigned CQ_TIMEOUT_MAX_CYC = (CORE_CLK_HZ / 1000) * CQ_TIMEOUT_MAX_MS;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin and startup counts, in oscillator periods
  localparam int unsigned MIN_RESET_PULSE_OSC = 2;
  localparam int unsigned RESET_STARTUP_OSC = 192;
  localparam int unsigned RESET_STARTUP_OSC_MAX = 196;

  ////////////////////////////////////////////////////////////////////////////
  // Recovery times, in bus cycles (bus clock is the core clock)
  localparam int unsigned WAIT_RECOVERY_CYC = 14;
  localparam int unsigned REG_RECOVERY_NS = 5000;
  localparam int unsigned REG_RECOVERY_CYC = (REG_RECOVERY_NS * CLK_PER_US + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // Clock monitor measurement
  localparam int unsigned MON_WINDOW_NS = 100_000;
  localparam int unsigned MON_WINDOW_CYC = MON_WINDOW_NS * CLK_PER_US / 1000;
  localparam int unsigned MON_FAIL_MIN_KHZ = 50;
  localparam int unsigned MON_FAIL_MAX_KHZ = 200;
  localparam int unsigned MON_FAIL_KHZ = 100;
  localparam int unsigned MON_FAIL_EDGES = MON_FAIL_KHZ * MON_WINDOW_NS / 1_000_000;
  localparam int unsigned QC_GOOD_WINDOWS = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Strap encoding and reset values
  localparam logic OSC_TYPE_PIERCE = 1'b0;
  localparam logic OSC_TYPE_COLPITTS = 1'b1;
  localparam logic POR_FLAG_RESET = 1'b1;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_QC,
    ST_EXT_RST,
    ST_RST_STARTUP,
    ST_RUN,
    ST_WAIT,
    ST_PSTOP,
    ST_STOP,
    ST_STOP_QC,
    ST_WAKE
  } seq_state_t;

endpackage : startup_seq_pkg

// [tb_startup_clock_quality_sequencer.sv]
// Self-checking bench for the startup and clock quality sequencer.
// Assumes a 2 MHz oscillator model and a shortened check time-out.
`timescale 1ns/1ps
`default_nettype none
module tb_startup_clock_quality_sequencer;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic lvr_reset = 1'b0;
  logic ext_reset_pin_n = 1'b1;
  logic osc_type_select_strap = 1'b1;
  logic ext_irq_pin = 1'b0;
  logic int_irq = 1'b0;
  logic stop_req = 1'b0;
  logic pseudo_stop_req = 1'b0;
  logic wait_req = 1'b0;
  logic por_flag_clear = 1'b0;
  logic osc_run = 1'b1;
  logic osc_pin, cpu_reset, sys_clk_enable, self_clock_mode, osc_enable, regulator_reduced;
  logic fetch_int_vector, clock_monitor_fail, power_on_reset_flag, osc_colpitts_sel;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;

  startup_clock_quality_sequencer #(.CQ_TIMEOUT_CYC(20000)) DUT (.core_clk, .sys_rst, .lvr_reset,
    .osc_pin, .ext_reset_pin_n, .osc_type_select_strap, .ext_irq_pin, .int_irq, .stop_req,
    .pseudo_stop_req, .wait_req, .por_flag_clear, .cpu_reset, .sys_clk_enable, .self_clock_mode,
    .osc_enable, .regulator_reduced, .fetch_int_vector, .clock_monitor_fail, .power_on_reset_flag,
    .osc_colpitts_sel);
  ext_clock_source u_osc (.run(osc_run), .osc_enable(osc_enable), .osc_pin(osc_pin));

  ////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      fails++;
      complete_run();
    end
  end

  // Comparison, waiting and closing helpers
  task automatic check_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit
  task automatic check_range(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : check_range
  function automatic logic hit(input int sel);
    case (sel)
      0: hit = (cpu_reset === 1'b0);
      1: hit = (fetch_int_vector === 1'b1);
      2: hit = (clock_monitor_fail === 1'b1);
      default: hit = (self_clock_mode === 1'b0);
    endcase
  endfunction : hit
  task automatic wait_for(input int sel, input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim && !hit(sel))
    begin
      @(negedge core_clk);
      cnt++;
    end
  endtask : wait_for
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////
  // Power-on start with a good oscillator and the strap high
  task automatic t_power_on();
    wait_for(0, 12000, n);
    check_range(n, 7000, 10500);
    check_bit(sys_clk_enable, 1'b1);
    check_bit(self_clock_mode, 1'b0);
    check_bit(power_on_reset_flag, 1'b1);
    check_bit(osc_colpitts_sel, 1'b1);
    @(negedge core_clk) por_flag_clear = 1'b1;
    @(negedge core_clk) por_flag_clear = 1'b0;
    check_bit(power_on_reset_flag, 1'b0);
  endtask : t_power_on

  // Wait ignores silence, then wakes on an internal interrupt
  task automatic t_wait();
    @(negedge core_clk) wait_req = 1'b1;
    @(negedge core_clk) wait_req = 1'b0;
    wait_for(1, 30, n);
    check_range(n, 30, 30);
    check_bit(sys_clk_enable, 1'b0);
    int_irq = 1'b1;
    wait_for(1, 40, n);
    int_irq = 1'b0;
    check_range(n, 1, 16);
    check_bit(sys_clk_enable, 1'b1);
  endtask : t_wait

  // Pseudo stop with reduced regulator, woken by the interrupt pin
  task automatic t_pstop();
    @(negedge core_clk) pseudo_stop_req = 1'b1;
    @(negedge core_clk) pseudo_stop_req = 1'b0;
    repeat (2) @(negedge core_clk);
    check_bit(regulator_reduced, 1'b1);
    check_bit(osc_enable, 1'b1);
    ext_irq_pin = 1'b1;
    wait_for(1, 200, n);
    ext_irq_pin = 1'b0;
    check_range(n, 114, 120);
    check_bit(regulator_reduced, 1'b0);
  endtask : t_pstop

  // Reset pin: a glitch is ignored, a long pulse skips the check
  task automatic t_ext_reset();
    // glitch far shorter than two periods
    @(negedge core_clk) ext_reset_pin_n = 1'b0;
    repeat (3) @(negedge core_clk);
    ext_reset_pin_n = 1'b1;
    repeat (20) @(negedge core_clk);
    check_bit(cpu_reset, 1'b0);
    ext_reset_pin_n = 1'b0;
    repeat (40) @(negedge core_clk);
    check_bit(cpu_reset, 1'b1);
    ext_reset_pin_n = 1'b1;
    wait_for(0, 12000, n);
    check_range(n, 1890, 2010);
    check_bit(power_on_reset_flag, 1'b0);
  endtask : t_ext_reset

  // Stop: internal interrupt refused, pin wake runs a full check
  task automatic t_stop();
    @(negedge core_clk) stop_req = 1'b1;
    @(negedge core_clk) stop_req = 1'b0;
    @(negedge core_clk) int_irq = 1'b1;
    repeat (20) @(negedge core_clk);
    int_irq = 1'b0;
    check_bit(osc_enable, 1'b0);
    ext_irq_pin = 1'b1;
    wait_for(1, 12000, n);
    ext_irq_pin = 1'b0;
    check_range(n, 7000, 10600);
    check_bit(self_clock_mode, 1'b0);
  endtask : t_stop

  // Oscillator dies in run, then comes back
  task automatic t_osc_fail();
    osc_run = 1'b0;
    wait_for(2, 6000, n);
    check_range(n, 1, 4200);
    @(negedge core_clk);
    check_bit(self_clock_mode, 1'b1);
    check_bit(sys_clk_enable, 1'b1);
    osc_run = 1'b1;
    wait_for(3, 12000, n);
    check_range(n, 7000, 10500);
  endtask : t_osc_fail

  // Low-voltage reset with no oscillation falls back to self clock
  task automatic t_timeout();
    osc_type_select_strap = 1'b0;
    osc_run = 1'b0;
    @(negedge core_clk) lvr_reset = 1'b1;
    repeat (4) @(negedge core_clk);
    lvr_reset = 1'b0;
    wait_for(0, 22000, n);
    check_range(n, 19000, 20300);
    check_bit(self_clock_mode, 1'b1);
    check_bit(osc_colpitts_sel, 1'b0);
    check_bit(power_on_reset_flag, 1'b0);
  endtask : t_timeout

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (12) @(negedge core_clk);
    sys_rst = 1'b0;
    t_power_on();
    t_wait();
    t_pstop();
    t_ext_reset();
    t_stop();
    t_osc_fail();
    t_timeout();
    complete_run();
  end
endmodule : tb_startup_clock_quality_sequencer
`default_nettype wire
